// ### design/io_port_watchdog_timer.sv
// Watchdog timer armed and disarmed by host I/O port writes.
// Assumes the I/O write bus is synchronous to ref_clk_i; the jumper is an async board level.
//
// Operation
// [R01] Writing the enable port arms the watchdog; expiry triggers the selected action.
// [R02] Writing the disable port stops the watchdog until armed again.
// [R03] Data written to the disable port is ignored.
// [R04] Enable data value v selects a timeout of (15 - v) times 8 seconds.
// [R05] Expiry raises either system reset or NMI, chosen by a board jumper.
// [R06] Actual timeout stays within a quarter of its nominal value.
// [R07] Software should refresh the watchdog about once a second.
// [R08] Every enable write reloads the countdown and acts as the refresh.
`timescale 1ns/100ps
module io_port_watchdog_timer #(
    parameter int CYCLES_PER_SEC = wdt_pkg::CYCLES_PER_TICK
) (
    input wire logic ref_clk_i, // 40 MHz reference clock
    input wire logic rst_i, // Synchronous reset, active high
    input wire wdt_pkg::io_wr_t io_bus_i, // Host I/O write: strobe, address, data
    input wire logic jumper_nmi_i, // Board jumper: 1 selects NMI, 0 system reset
    output logic sys_reset_o, // Reset pulse on expiry, active high
    output logic nmi_o, // NMI pulse on expiry, active high
    output logic armed_o // Watchdog is counting
);
    import wdt_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Port decode and jumper synchroniser

    logic enable_hit;
    logic disable_hit;
    logic [TIMEOUT_SEL_W-1:0] timeout_sel;
    logic [SECS_W-1:0] load_secs;
    logic jmp_meta_reg;
    logic jmp_sync_reg;
    logic tick;

    // Disable decode looks at the address only; the data word plays no part
    assign disable_hit = io_bus_i.wr && (io_bus_i.addr == DISABLE_PORT_ADDR); // R02 R03
    assign enable_hit = io_bus_i.wr && (io_bus_i.addr == ENABLE_PORT_ADDR); // R01
    assign timeout_sel = io_bus_i.data[TIMEOUT_SEL_LSB +: TIMEOUT_SEL_W];
    // Level F gives zero seconds, level 0 gives the longest wait
    assign load_secs = {TIMEOUT_SEL_MAX - timeout_sel, {STEP_SHIFT{1'b0}}}; // R04

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            jmp_meta_reg <= 1'b0;
            jmp_sync_reg <= 1'b0;
        end else begin
            jmp_meta_reg <= jumper_nmi_i;
            jmp_sync_reg <= jmp_meta_reg;
        end
    end

    // Restarting the prescaler on each enable write makes every interval whole seconds
    wdt_prescaler #(
        .CYCLES(CYCLES_PER_SEC)
    ) u_prescaler (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .restart_i(enable_hit), // R06 R08
        .tick_o(tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Countdown and expiry state

    wdt_state_t state_reg;
    wdt_state_t state_next;
    logic [SECS_W-1:0] secs_reg;
    logic [SECS_W-1:0] secs_next;
    logic [PULSE_W-1:0] pulse_reg;
    logic [PULSE_W-1:0] pulse_next;
    logic use_nmi_reg;
    logic use_nmi_next;
    logic sys_reset_next;
    logic nmi_next;
    logic armed_next;

    always_comb begin
        state_next = state_reg;
        secs_next = secs_reg;
        pulse_next = pulse_reg;
        use_nmi_next = use_nmi_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (enable_hit) begin
                    state_next = ST_ARMED; // R01
                    secs_next = load_secs; // R04
                end
            end
            ST_ARMED: begin
                if (disable_hit) begin
                    state_next = ST_IDLE; // R02
                end else if (enable_hit) begin
                    secs_next = load_secs; // R08
                end else if (secs_reg == '0) begin
                    state_next = ST_FIRE; // R01
                    pulse_next = PULSE_W'(PULSE_CYCLES - 1);
                    use_nmi_next = jmp_sync_reg; // R05
                end else if (tick) begin
                    secs_next = secs_reg - SECS_W'(1); // R06
                end
            end
            ST_FIRE: begin
                // A refresh or disable write ends the pulse at once; a refresh also arms again
                if (disable_hit) begin
                    state_next = ST_IDLE; // R02
                end else if (enable_hit) begin
                    state_next = ST_ARMED; // R08
                    secs_next = load_secs;
                end else if (pulse_reg == '0) begin
                    state_next = ST_IDLE;
                end else begin
                    pulse_next = pulse_reg - PULSE_W'(1);
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        sys_reset_next = (state_next == ST_FIRE) && !use_nmi_next; // R05
        nmi_next = (state_next == ST_FIRE) && use_nmi_next; // R05
        armed_next = (state_next == ST_ARMED);
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            secs_reg <= SECS_RESET;
            pulse_reg <= PULSE_RESET;
            use_nmi_reg <= 1'b0;
            sys_reset_o <= 1'b0;
            nmi_o <= 1'b0;
            armed_o <= 1'b0;
        end else begin
            state_reg <= state_next;
            secs_reg <= secs_next;
            pulse_reg <= pulse_next;
            use_nmi_reg <= use_nmi_next;
            sys_reset_o <= sys_reset_next;
            nmi_o <= nmi_next;
            armed_o <= armed_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    logic firing;
    assign firing = sys_reset_o || nmi_o;

    a_enable_arms: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R01
        enable_hit |=> armed_o && (state_reg == ST_ARMED))
        else $error("enable write did not arm the watchdog");

    a_disable_stops: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R02
        disable_hit |=> !armed_o ##1 !firing)
        else $error("disable write did not stop the watchdog");

    a_idle_is_quiet: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R02
        (state_reg == ST_IDLE) && !enable_hit |=> !firing && !armed_o)
        else $error("expiry action while stopped");

    a_disable_data_free: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R03
        disable_hit && (state_reg == ST_ARMED) |=> (state_reg == ST_IDLE) && !firing)
        else $error("disable write data changed the outcome");

    a_load_level: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R04
        enable_hit |=> secs_reg == {~$past(io_bus_i.data[3:0]), 3'b000})
        else $error("timeout level loaded wrongly");

    a_zero_level: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R04
        enable_hit && (io_bus_i.data[3:0] == 4'hf) ##1 !io_bus_i.wr |=> firing)
        else $error("level F did not expire at once");

    a_action_select: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R05
        $rose(firing) |-> (nmi_o == $past(jmp_sync_reg)) && (sys_reset_o == !$past(jmp_sync_reg)))
        else $error("expiry action does not follow the jumper");

    a_single_action: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R05
        !(sys_reset_o && nmi_o))
        else $error("reset and NMI raised together");

    a_tick_countdown: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R06
        (state_reg == ST_ARMED) && tick && !io_bus_i.wr && (secs_reg != '0)
        |=> secs_reg == $past(secs_reg) - 7'h01)
        else $error("countdown did not follow the second tick");

    a_no_early_fire: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R06
        (state_reg == ST_ARMED) && (secs_reg != '0) |=> !firing)
        else $error("expiry before the countdown ran out");

    a_refresh_reload: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R08
        (state_reg == ST_ARMED) && enable_hit |=> armed_o && !firing)
        else $error("refresh did not reload the countdown");

    // Outputs mirror the fire state, so firing stands for the whole pulse
    a_expiry_fires: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R01
        (state_reg == ST_ARMED) && (secs_reg == '0) && !io_bus_i.wr |=> firing && !armed_o)
        else $error("countdown ran out without an expiry action");

    a_fire_after_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R06
        $rose(firing) |-> ($past(state_reg) == ST_ARMED) && ($past(secs_reg) == '0))
        else $error("expiry action without an expired countdown");

    a_pulse_holds: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R05
        firing && (pulse_reg != '0) && !io_bus_i.wr |=> firing && $stable(nmi_o))
        else $error("expiry pulse cut short or changed action");

    a_pulse_ends: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R01
        firing && (pulse_reg == '0) && !io_bus_i.wr |=> !firing && !armed_o)
        else $error("expiry pulse did not end");

    c_reset_fired: cover property (@(posedge ref_clk_i) disable iff (rst_i) $rose(sys_reset_o));
    c_nmi_fired: cover property (@(posedge ref_clk_i) disable iff (rst_i) $rose(nmi_o));
    c_refreshed: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        (state_reg == ST_ARMED) && tick ##[1:20] enable_hit);
    c_disarmed: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        (state_reg == ST_ARMED) && disable_hit);
    c_zero_level: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        enable_hit && (timeout_sel == TIMEOUT_SEL_MAX));

endmodule : io_port_watchdog_timer

// ### design/wdt_pkg.sv
// Constants, types and timing for the I/O port watchdog timer.
// Assumes a 40 MHz reference clock and a host I/O write bus on that clock.
package wdt_pkg;

    // Port addresses
    localparam logic [15:0] DISABLE_PORT_ADDR = 16'h0441;
    localparam logic [15:0] ENABLE_PORT_ADDR = 16'h0443;

    // Field layout of the enable port data word
    localparam int TIMEOUT_SEL_LSB = 0;
    localparam int TIMEOUT_SEL_W = 4;
    // Seconds per timeout level is 8, applied as a shift
    localparam int STEP_SHIFT = 3;
    localparam int SECS_W = TIMEOUT_SEL_W + STEP_SHIFT;
    localparam logic [TIMEOUT_SEL_W-1:0] TIMEOUT_SEL_MAX = 4'hf;

    // Clock and timing
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_MHZ = 40;
    localparam int TICK_SEC = 1;
    localparam int CYCLES_PER_TICK = TICK_SEC * CLK_HZ;
    localparam int PRESCALE_W = 26;
    // Width of the reset or NMI pulse on expiry
    localparam int PULSE_NS = 1000;
    localparam int PULSE_CYCLES = (PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int PULSE_W = 8;

    // Reset values
    localparam logic [SECS_W-1:0] SECS_RESET = 7'h00;
    localparam logic [PULSE_W-1:0] PULSE_RESET = 8'h00;

    // One host I/O write cycle
    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic [15:0] data;
    } io_wr_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARMED = 3'b010,
        ST_FIRE = 3'b100
    } wdt_state_t;

endpackage : wdt_pkg

// ### design/wdt_prescaler.sv
// One-second tick generator for the watchdog countdown.
// Assumes restart_i is a one-cycle pulse on the same clock.
`timescale 1ns/100ps
module wdt_prescaler #(
    parameter int CYCLES = 40_000_000
) (
    input wire logic ref_clk_i, // Reference clock
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic restart_i, // Start a fresh tick period
    output logic tick_o // One-cycle pulse per period
);
    import wdt_pkg::*;

    localparam logic [PRESCALE_W-1:0] LAST = PRESCALE_W'(CYCLES - 1);

    logic [PRESCALE_W-1:0] cnt_reg;
    logic [PRESCALE_W-1:0] cnt_next;
    logic tick_next;

    always_comb begin
        cnt_next = cnt_reg + PRESCALE_W'(1);
        tick_next = 1'b0;
        if (restart_i) begin
            cnt_next = '0;
        end else if (cnt_reg == LAST) begin
            cnt_next = '0;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cnt_reg <= '0;
            tick_o <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_o <= tick_next;
        end
    end

    // Between restarts, ticks are exactly CYCLES apart, keeping every interval well inside the tolerance band
    a_tick_spacing: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        tick_o |-> cnt_reg == '0) // R06
        else $error("tick out of step with prescale counter");

endmodule : wdt_prescaler

// ### testbench/host_io_model.sv
// Host-side model that issues I/O port writes the way driving software would.
// Assumes callers run in the ref_clk_i domain; one write at a time.
`timescale 1ns/100ps
module host_io_model (
    input wire logic ref_clk_i, // Bus clock
    output wdt_pkg::io_wr_t io_bus_o // Write cycle to the device
);
    import wdt_pkg::*;

    initial begin
        io_bus_o = '0;
    end

    // Strobe for one cycle; released lines show the inverse, not the last value
    task automatic io_write(input logic [15:0] addr, input logic [15:0] data);
        @(posedge ref_clk_i);
        io_bus_o <= '{wr: 1'b1, addr: addr, data: data};
        @(posedge ref_clk_i);
        io_bus_o <= '{wr: 1'b0, addr: ~addr, data: ~data};
    endtask : io_write

    // Healthy software refreshes well inside the timeout
    task automatic refresh(input logic [3:0] level, input int period, input int count);
        for (int i = 0; i < count; i++) begin
            repeat (period - 2) @(posedge ref_clk_i);
            io_write(ENABLE_PORT_ADDR, {12'h000, level});
        end
    endtask : refresh
endmodule : host_io_model

// ### testbench/io_port_watchdog_timer_bench.sv
// Self-checking bench for the I/O port watchdog timer.
// Assumes a shortened second of N cycles; the host model drives all writes.
`timescale 1ns/100ps
module io_port_watchdog_timer_bench;
    import wdt_pkg::*;
    localparam int N = 10;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic jumper_nmi_i = 1'b0;
    io_wr_t io_bus;
    logic sys_reset_o;
    logic nmi_o;
    logic armed_o;
    int num_errors = 0;
    int num_checks = 0;

    always #12.5 ref_clk_i = ~ref_clk_i;

    host_io_model host_u (.ref_clk_i(ref_clk_i), .io_bus_o(io_bus));
    io_port_watchdog_timer #(.CYCLES_PER_SEC(N)) dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .io_bus_i(io_bus), .jumper_nmi_i(jumper_nmi_i), .sys_reset_o(sys_reset_o), .nmi_o(nmi_o),
        .armed_o(armed_o));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : chk

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : settle

    // Counted from the edge just passed; fires exactly t edges later
    task automatic expect_fire(input int t, input logic nmi_sel);
        settle(t - 1);
        chk("no early action", 1'b0, sys_reset_o | nmi_o);
        settle(1);
        chk("sys_reset_o", ~nmi_sel, sys_reset_o);
        chk("nmi_o", nmi_sel, nmi_o);
        chk("armed_o after expiry", 1'b0, armed_o);
        settle(PULSE_CYCLES - 1);
        chk("pulse held", 1'b1, sys_reset_o | nmi_o);
        settle(1);
        chk("pulse ended", 1'b0, sys_reset_o | nmi_o);
    endtask : expect_fire

    ////////////////////////////////////////////////////////////////////////////
    // Every level, upper data bits noisy, jumper alternating
    task automatic test_levels();
        for (int v = 0; v < 16; v++) begin
            @(posedge ref_clk_i);
            jumper_nmi_i <= v[0];
            settle(3);
            host_u.io_write(ENABLE_PORT_ADDR, {12'h5a5, v[3:0]});
            #1;
            chk("armed_o after enable", 1'b1, armed_o);
            // Level F fires on the edge after the write; others two edges after the last tick
            expect_fire((v == 15) ? 1 : (15 - v) * 8 * N + 2, v[0]);
        end
    endtask : test_levels

    task automatic test_disable();
        for (int i = 0; i < 2; i++) begin
            host_u.io_write(ENABLE_PORT_ADDR, 16'h000e);
            settle(20);
            host_u.io_write(DISABLE_PORT_ADDR, {16{i[0]}});
            settle(1);
            chk("armed_o after disable", 1'b0, armed_o);
            settle(100);
            chk("no action after disable", 1'b0, sys_reset_o | nmi_o);
        end
    endtask : test_disable

    // Refresh reloads; then a refresh to level F shortens the wait
    task automatic test_refresh();
        @(posedge ref_clk_i);
        jumper_nmi_i <= 1'b0;
        host_u.io_write(ENABLE_PORT_ADDR, 16'h000e);
        host_u.refresh(4'he, 50, 3);
        #1;
        chk("armed_o while refreshed", 1'b1, armed_o);
        expect_fire(8 * N + 2, 1'b0);
        host_u.io_write(ENABLE_PORT_ADDR, 16'h000e);
        host_u.io_write(ENABLE_PORT_ADDR, 16'h000f);
        expect_fire(1, 1'b0);
    endtask : test_refresh

    task automatic test_unmapped();
        host_u.io_write(16'h0442, 16'h000f);
        settle(5);
        chk("armed_o after unmapped write", 1'b0, armed_o);
        chk("no action after unmapped write", 1'b0, sys_reset_o | nmi_o);
    endtask : test_unmapped

    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("Checks made: %0d, errors: %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    initial begin
        settle(19);
        chk("armed_o in reset", 1'b0, armed_o);
        @(posedge ref_clk_i);
        rst_i <= 1'b0;
        test_unmapped();
        test_levels();
        test_disable();
        test_refresh();
        print_verdict();
    end

    // Whole run needs about 11000 cycles
    initial begin
        #(25 * 20000);
        num_errors++;
        print_verdict();
    end
endmodule : io_port_watchdog_timer_bench
